//--- lock_power_map.svh
// register map and timing constants for the lock and idle power block
`ifndef LOCK_POWER_MAP_SVH
`define LOCK_POWER_MAP_SVH
`define CTRL_OFFSET 8'h34
`define CTRL_RESET 8'h3F
`define PPM_RDY_BIT 7
`define IDLE_INHIBIT_BIT 6
`define RETRY_HI_BIT 5
`define RETRY_LO_BIT 4
`define IDLE_TIME_MS 100
`define CLOCK_MHZ 250
`define IDLE_CYCLES (`IDLE_TIME_MS * 1000 * `CLOCK_MHZ)
`endif

//--- lock_power_pkg.sv
// types for the lock and idle power block
package lock_power_pkg;
  typedef enum logic [1:0] {LOCK_SEARCH, LOCK_HELD, LOCK_RECHECK} lock_state_e;
endpackage

//--- idle_timer.sv
// idle timer: counts while signal detect is low
`timescale 1ns/1ps
`include "lock_power_map.svh"
module idle_timer #(
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic signalDetect,
  output logic expired
);
  typedef struct packed {
    logic [31:0] count;
    logic expired;
  } timer_s;
  timer_s state_q;
  timer_s state_d;

  // count up to the limit and hold; any return of signal restarts it
  // idle time count
  always_comb begin
    state_d = state_q;
    if (signalDetect) begin
      state_d.count = 32'h00000000;
      state_d.expired = 1'b0;
    end else if (state_q.count >= IDLE_CYCLES[31:0] - 32'h00000001) begin
      state_d.expired = 1'b1;
    end else begin
      state_d.count = state_q.count + 32'h00000001;
    end
  end

  // reset clears the count so no false expiry follows reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end
  assign expired = state_q.expired;
endmodule

//--- cdr_lock_monitor_idle_power.sv
// lock-loss filter, idle power-down and ppm ready flag for one channel
`timescale 1ns/1ps
`include "lock_power_map.svh"
module cdr_lock_monitor_idle_power #(
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic lockCheck,
  input wire logic lockPass,
  input wire logic ppmCountNew,
  input wire logic signalDetect,
  output logic lockDetect,
  output logic powerDown
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // all state in one packed struct, registered as a whole
  typedef struct packed {
    lock_power_pkg::lock_state_e lockState;
    logic [1:0] recheck;
    logic lockDetect;
    logic powerDown;
    logic ppmReady;
    logic idleInhibit;
    logic [1:0] retryCount;
    logic [3:0] spare;
    logic [7:0] rdata;
  } ctrl_s;
  ctrl_s state_q;
  ctrl_s state_d;
  logic idleExpired;
  logic ctrlHit;

  // the timer runs on the same clock, so its expiry needs no crossing
  idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle_timer (
    .clock(clock),
    .rst_n(rst_n),
    .signalDetect(signalDetect),
    .expired(idleExpired)
  );

  // only the control byte is decoded; every other address reads zero
  assign ctrlHit = (regAddr == `CTRL_OFFSET);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // one pass builds the whole next state; outputs are then plain flops
  always_comb begin
    state_d = state_q;
    // register write first so hardware events below win over it
    // writing the ready bit low acknowledges the count just read
    if (regWrite && ctrlHit) begin
      state_d.ppmReady = regWdata[`PPM_RDY_BIT];
      state_d.idleInhibit = regWdata[`IDLE_INHIBIT_BIT];
      state_d.retryCount = regWdata[`RETRY_HI_BIT:`RETRY_LO_BIT];
      state_d.spare = regWdata[3:0];
    end
    if (ppmCountNew) begin
      state_d.ppmReady = 1'b1;
    end
    // signal detect itself stays powered; only the other blocks follow
    // idle power-down
    state_d.powerDown = idleExpired && !state_d.idleInhibit;
    // lock filter acts only on a check strobe
    // retry field N allows N rechecks after the first failure: N+1 fails drop lock
    // a field rewritten at or below the recheck count mid-sequence ends it at the next failure
    if (lockCheck) begin
      unique case (state_q.lockState)
        lock_power_pkg::LOCK_SEARCH: begin
          if (lockPass) begin
            state_d.lockState = lock_power_pkg::LOCK_HELD;
            state_d.lockDetect = 1'b1;
            state_d.recheck = 2'h0;
          end
        end
        lock_power_pkg::LOCK_HELD: begin
          if (!lockPass) begin
            if (state_q.retryCount == 2'h0) begin
              state_d.lockState = lock_power_pkg::LOCK_SEARCH;
              state_d.lockDetect = 1'b0;
            end else begin
              state_d.lockState = lock_power_pkg::LOCK_RECHECK;
              state_d.recheck = 2'h1;
            end
          end
        end
        lock_power_pkg::LOCK_RECHECK: begin
          if (lockPass) begin
            state_d.lockState = lock_power_pkg::LOCK_HELD;
            state_d.recheck = 2'h0;
          end else if (state_q.recheck >= state_q.retryCount) begin
            state_d.lockState = lock_power_pkg::LOCK_SEARCH;
            state_d.lockDetect = 1'b0;
            state_d.recheck = 2'h0;
          end else begin
            state_d.recheck = state_q.recheck + 2'h1;
          end
        end
        // the unused state code falls back to search with a clean counter
        default: begin
          state_d.lockState = lock_power_pkg::LOCK_SEARCH;
          state_d.lockDetect = 1'b0;
          state_d.recheck = 2'h0;
        end
      endcase
    end
    // read data registered; unmapped addresses read zero
    if (regRead) begin
      state_d.rdata = ctrlHit ? {state_d.ppmReady, state_d.idleInhibit,
                                 state_d.retryCount, state_d.spare} : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // reset loads constants only; the control byte comes up as 8'h3F
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q.lockState <= lock_power_pkg::LOCK_SEARCH;
      state_q.recheck <= 2'h0;
      state_q.lockDetect <= 1'b0;
      state_q.powerDown <= 1'b0;
      state_q.ppmReady <= 1'b0;
      state_q.idleInhibit <= 1'b0;
      state_q.retryCount <= 2'h3;
      state_q.spare <= 4'hF;
      state_q.rdata <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs come straight from the state flops
  assign regRdata = state_q.rdata;
  assign lockDetect = state_q.lockDetect;
  assign powerDown = state_q.powerDown;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // ready flag and idle power-down
  // ------------------------------------------------------------

  a_ppm_ready_set: assert property (ppmCountNew |=> state_q.ppmReady)
    else $error("ppm ready not set");
  a_ready_clear: assert property ((regWrite && ctrlHit && !ppmCountNew
      && !regWdata[`PPM_RDY_BIT]) |=> !state_q.ppmReady)
    else $error("ppm ready not cleared by write");
  a_ready_readable: assert property ((regRead && ctrlHit)
      |=> regRdata[`PPM_RDY_BIT] == state_q.ppmReady)
    else $error("ppm ready not shown on read");
  a_idle_power_down: assert property ((idleExpired && !state_q.idleInhibit
      && !(regWrite && ctrlHit)) |=> powerDown)
    else $error("idle power-down missing");
  a_no_power_signal: assert property (signalDetect [*2] |=> !powerDown)
    else $error("powered down with signal");
  a_inhibit_blocks: assert property (state_q.idleInhibit |-> !powerDown)
    else $error("powered down while inhibited");

  // ------------------------------------------------------------
  // lock-loss filter
  // ------------------------------------------------------------

  a_check_gates: assert property (!lockCheck |=> $stable(state_q.lockState))
    else $error("lock state moved without a check");
  a_recheck_bound: assert property ((state_q.lockState != lock_power_pkg::LOCK_RECHECK)
      |-> state_q.recheck == 2'h0)
    else $error("recheck counter left running");
  a_fail_keeps_lock: assert property ((state_q.lockState == lock_power_pkg::LOCK_HELD
      && lockCheck && !lockPass && state_q.retryCount != 2'h0) |=> lockDetect)
    else $error("lock dropped on first recheck");
  a_loss_no_retry: assert property ((state_q.lockState == lock_power_pkg::LOCK_HELD
      && lockCheck && !lockPass && state_q.retryCount == 2'h0) |=> !lockDetect)
    else $error("lock kept with no retries");
  a_regain_clears: assert property ((state_q.lockState == lock_power_pkg::LOCK_RECHECK
      && lockCheck && lockPass) |=> (lockDetect && state_q.recheck == 2'h0))
    else $error("regain did not clear");
  a_locked_states: assert property ((state_q.lockState != lock_power_pkg::LOCK_SEARCH)
      |-> lockDetect)
    else $error("lock low outside search");
  a_loss_declared: assert property ((state_q.lockState == lock_power_pkg::LOCK_RECHECK
      && lockCheck && !lockPass && state_q.recheck >= state_q.retryCount)
      |=> !lockDetect)
    else $error("loss not declared");
  a_gain_on_pass: assert property ((state_q.lockState == lock_power_pkg::LOCK_SEARCH
      && lockCheck && lockPass) |=> lockDetect)
    else $error("lock not gained on pass");
  a_loss_holds: assert property ((!lockDetect && !(lockCheck && lockPass))
      |=> !lockDetect)
    else $error("lock rose without pass");

  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------

  c_ready_flag: cover property (!state_q.ppmReady ##1 state_q.ppmReady);
  c_lock_gained: cover property (!lockDetect ##1 lockDetect);
  c_lock_lost: cover property (lockDetect ##1 !lockDetect);
  c_regained: cover property (state_q.lockState == lock_power_pkg::LOCK_RECHECK
      ##1 state_q.lockState == lock_power_pkg::LOCK_HELD);
  c_power_down: cover property (!powerDown ##1 powerDown);
endmodule

//--- cdr_lock_monitor_idle_power_tb.sv
// self-checking bench for the lock and idle power block
`timescale 1ns/1ps
`include "lock_power_map.svh"
module cdr_lock_monitor_idle_power_tb;
  // short idle count keeps the run brief; expectations derive from it
  localparam int unsigned IdleCycles = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic lockCheck = 1'b0;
  logic lockPass = 1'b0;
  logic ppmCountNew = 1'b0;
  logic signalDetect = 1'b1;
  logic lockDetect;
  logic powerDown;
  logic [7:0] rdVal;
  int n_errors = 0;
  int check_count = 0;

  always #2 clock = ~clock;

  cdr_lock_monitor_idle_power #(.IDLE_CYCLES(IdleCycles)) dut (
    .clock(clock), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .lockCheck(lockCheck), .lockPass(lockPass), .ppmCountNew(ppmCountNew),
    .signalDetect(signalDetect), .lockDetect(lockDetect), .powerDown(powerDown)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // inputs move on the falling edge; the rising edge between takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) begin regWrite = 1'b1; regAddr = a; regWdata = d; end
    @(negedge clock) regWrite = 1'b0;
  endtask

  // read data lands one edge after the request, settled by the next fall
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock) begin regRead = 1'b1; regAddr = a; end
    @(negedge clock) regRead = 1'b0;
    d = regRdata;
  endtask

  task automatic lockEval(input logic p);
    @(negedge clock) begin lockCheck = 1'b1; lockPass = p; end
    @(negedge clock) lockCheck = 1'b0;
  endtask

  task automatic summarize();
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    rd(`CTRL_OFFSET, rdVal);
    chk("ctrl reset", rdVal, `CTRL_RESET);
    rd(8'h35, rdVal);
    chk("unmapped read", rdVal, 8'h00);
    // ready flag rises on a fresh count and clears on write of zero
    @(negedge clock) ppmCountNew = 1'b1;
    @(negedge clock) ppmCountNew = 1'b0;
    rd(`CTRL_OFFSET, rdVal);
    chk("ppm ready set", rdVal, 8'hBF);
    wr(`CTRL_OFFSET, 8'h3F);
    rd(`CTRL_OFFSET, rdVal);
    chk("ppm ready clear", rdVal, 8'h3F);
    // retry field 3: three fails then a pass keep lock, four fails drop it
    lockEval(1'b1);
    chk("lock gained", lockDetect, 1'b1);
    repeat (3) lockEval(1'b0);
    chk("lock during rechecks", lockDetect, 1'b1);
    lockEval(1'b1);
    chk("lock after regain", lockDetect, 1'b1);
    // counter cleared by the pass, so three more fails still hold lock
    repeat (3) lockEval(1'b0);
    chk("counter cleared", lockDetect, 1'b1);
    lockEval(1'b0);
    chk("lock lost", lockDetect, 1'b0);
    lockEval(1'b0);
    chk("lock stays low", lockDetect, 1'b0);
    // retry field 0: a single fail drops lock at once
    wr(`CTRL_OFFSET, 8'h0F);
    lockEval(1'b1);
    chk("relock", lockDetect, 1'b1);
    lockEval(1'b0);
    chk("lock lost no retry", lockDetect, 1'b0);
    // retry field 1: one recheck, so the second fail in a row drops lock
    wr(`CTRL_OFFSET, 8'h1F);
    rd(`CTRL_OFFSET, rdVal);
    chk("retry one written", rdVal, 8'h1F);
    lockEval(1'b1);
    chk("relock retry one", lockDetect, 1'b1);
    lockEval(1'b0);
    chk("one recheck holds", lockDetect, 1'b1);
    lockEval(1'b0);
    chk("lock lost retry one", lockDetect, 1'b0);
    // idle power-down after the set count of absent signal
    @(negedge clock) signalDetect = 1'b0;
    repeat (IdleCycles) @(negedge clock);
    chk("power early", powerDown, 1'b0);
    @(negedge clock);
    chk("power down", powerDown, 1'b1);
    @(negedge clock) signalDetect = 1'b1;
    @(negedge clock);
    chk("power still down", powerDown, 1'b1);
    @(negedge clock);
    chk("power restored", powerDown, 1'b0);
    // inhibit set: no power-down however long the signal is gone
    wr(`CTRL_OFFSET, 8'h7F);
    @(negedge clock) signalDetect = 1'b0;
    repeat (IdleCycles + 10) @(negedge clock);
    chk("inhibit holds power", powerDown, 1'b0);
    // clearing inhibit while the signal is still gone powers down at once
    wr(`CTRL_OFFSET, 8'h3F);
    chk("inhibit lifted", powerDown, 1'b1);
    summarize();
  end

  // the sequence needs about 130 cycles; this margin is generous
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule
